/* core/qbc_map.svh */
`ifndef QBC_MAP_SVH
`define QBC_MAP_SVH

// sizes
`define QBC_NPORT     4
`define QBC_NLEG      4
`define QBC_NCLASS    8
`define QBC_NCP       32
`define QBC_NCODE     64
`define QBC_NTMAP     64
`define QBC_NTPID     5

// byte offsets of register regions
`define QBC_PORT_BASE 12'h000
`define QBC_LEG_BASE  12'h040
`define QBC_REWR_BASE 12'h080
`define QBC_CPC_BASE  12'h100
`define QBC_CODE_BASE 12'h200
`define QBC_TMAP_BASE 12'h400
`define QBC_STAT_ADDR 12'h600

// port / router leg config fields
`define QBC_F_QOS     2:0
`define QBC_F_DROP    4:3
`define QBC_F_TAGE    5
`define QBC_F_CODEE   6
`define QBC_F_TRE     7
`define QBC_F_INNER   8
`define QBC_F_KEEP    9
`define QBC_F_SVC     12:10
`define QBC_F_REWE    13
`define QBC_F_TPID    18:14
// port word after reset: all five tag types valid, rest clear
`define QBC_PORT_RST  19'h7_C000
// per codepoint entry fields
`define QBC_F_TRUST   5
`define QBC_F_TRVAL   11:6
`define QBC_F_CODE    5:0
// status word fields
`define QBC_S_CODE    10:5
`define QBC_S_SVC     13:11
`define QBC_S_CNT     31:16

`define QBC_RESP_OK   2'h0
`define QBC_RESP_ERR  2'h2

`endif

/* core/qbc_pkg.sv */
`default_nettype none
package qbc_pkg;

	typedef struct packed {
		logic [2:0] tpid_type;
		logic [2:0] pcp;
		logic       dei;
	} qbc_tag_t;

	typedef struct packed {
		logic [1:0]    port;
		logic [1:0]    tag_cnt;
		qbc_tag_t [2:0] tags;
		logic          is_ip;
		logic [5:0]    code;
		logic          l2cp_cpu;
		logic [4:0]    l2cp_idx;
		logic          from_second_vdev;
		logic          rleg_valid;
		logic [1:0]    rleg;
	} qbc_frame_t;

	typedef struct packed {
		logic [2:0] prio_class;
		logic [1:0] drop_prec;
		logic [5:0] code;
		logic [2:0] svc_class;
		logic       transp_code;
	} qbc_result_t;

endpackage
`default_nettype wire

/* core/qbc_tag_select.sv */
`timescale 1ns/1ps
`default_nettype none
module qbc_tag_select (
	input  wire qbc_pkg::qbc_tag_t [2:0] tags,
	input  wire logic [1:0]              tag_cnt,
	input  wire logic [4:0]              tpid_ok,
	input  wire logic                    inner_sel,
	output logic                         has_tag,
	output logic [2:0]                   pcp,
	output logic                         dei
);
	logic [2:0] valid;
	logic [1:0] nvalid;

	// types beyond the five known ones never count as tags
	function automatic logic tpid_known(input logic [4:0] mask,
		input logic [2:0] kind);
		logic [7:0] wide;
		wide = {3'h0, mask};
		return wide[kind];
	endfunction

	// a tag counts only while every tag before it counted
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_tag
			if (g == 0) begin : g_first
				assign valid[g] = (tag_cnt > 2'(g)) &&
					tpid_known(tpid_ok, tags[g].tpid_type);
			end else begin : g_rest
				assign valid[g] = valid[g-1] && (tag_cnt > 2'(g)) &&
					tpid_known(tpid_ok, tags[g].tpid_type);
			end
		end
	endgenerate

	always_comb begin
		nvalid = 2'(valid[0]) + 2'(valid[1]) + 2'(valid[2]);
		has_tag = valid[0];
		// inner is the tag right after the outer one
		if (inner_sel && nvalid >= 2'h2) begin
			pcp = tags[1].pcp;
			dei = tags[1].dei;
		end else begin
			pcp = tags[0].pcp;
			dei = tags[0].dei;
		end
	end
endmodule // qbc_tag_select
`default_nettype wire

/* core/qbc_axil_slave.sv */
`timescale 1ns/1ps
`default_nettype none
`include "qbc_map.svh"
module qbc_axil_slave (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [11:0] s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [11:0] s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	output logic             wr_go,
	output logic [11:0]      wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	input  wire logic        wr_hit,
	output logic [11:0]      rd_addr,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_hit
);
	logic rd_go;

	assign wr_go = ~s_awready & ~s_wready & ~s_bvalid;
	assign rd_go = ~s_arready & ~s_rvalid;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_awready <= 1'b1;
			wr_addr   <= 12'h000;
		end else if (s_awvalid && s_awready) begin
			s_awready <= 1'b0;
			wr_addr   <= s_awaddr;
		end else if (wr_go) begin
			s_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_wready <= 1'b1;
			wr_data  <= 32'h0000_0000;
			wr_strb  <= 4'h0;
		end else if (s_wvalid && s_wready) begin
			s_wready <= 1'b0;
			wr_data  <= s_wdata;
			wr_strb  <= s_wstrb;
		end else if (wr_go) begin
			s_wready <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_bvalid <= 1'b0;
			s_bresp  <= `QBC_RESP_OK;
		end else if (wr_go) begin
			s_bvalid <= 1'b1;
			s_bresp  <= wr_hit ? `QBC_RESP_OK : `QBC_RESP_ERR;
		end else if (s_bready) begin
			s_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_arready <= 1'b1;
			rd_addr   <= 12'h000;
		end else if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			rd_addr   <= s_araddr;
		end else if (s_rvalid && s_rready) begin
			s_arready <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h0000_0000;
			s_rresp  <= `QBC_RESP_OK;
		end else if (rd_go) begin
			s_rvalid <= 1'b1;
			s_rdata  <= rd_hit ? rd_data : 32'h0000_0000;
			s_rresp  <= rd_hit ? `QBC_RESP_OK : `QBC_RESP_ERR;
		end else if (s_rready) begin
			s_rvalid <= 1'b0;
		end
	end
endmodule // qbc_axil_slave
`default_nettype wire

/* core/qbc_classifier.sv */
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "qbc_map.svh"
module qbc_classifier (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic [11:0]        s_awaddr,
	input  wire logic               s_awvalid,
	output logic                    s_awready,
	input  wire logic [31:0]        s_wdata,
	input  wire logic [3:0]         s_wstrb,
	input  wire logic               s_wvalid,
	output logic                    s_wready,
	output logic [1:0]              s_bresp,
	output logic                    s_bvalid,
	input  wire logic               s_bready,
	input  wire logic [11:0]        s_araddr,
	input  wire logic               s_arvalid,
	output logic                    s_arready,
	output logic [31:0]             s_rdata,
	output logic [1:0]              s_rresp,
	output logic                    s_rvalid,
	input  wire logic               s_rready,
	input  wire logic               frame_valid,
	input  wire qbc_pkg::qbc_frame_t frame_in,
	output logic                    result_valid,
	output qbc_pkg::qbc_result_t    result_out
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	logic [18:0] port_cfg [`QBC_NPORT];
	logic [7:0]  leg_cfg  [`QBC_NLEG];
	logic [5:0]  rewr_mem [`QBC_NCLASS];
	logic [2:0]  cpc_mem  [`QBC_NCP];
	logic [11:0] code_mem [`QBC_NCODE];
	logic [4:0]  tmap_mem [`QBC_NTMAP];
	logic [15:0] cnt_reg;

	logic        wr_go;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic [11:0] rd_addr;
	logic [32:0] rd_word;
	logic [32:0] wr_old;
	logic [31:0] wr_new;

	function automatic logic in_rgn(input logic [11:0] a,
		input logic [11:0] base, input int words);
		logic [11:0] off;
		off = a - base;
		return (a >= base) && (off < 12'(words * 4)) && (a[1:0] == 2'h0);
	endfunction

	// returns {hit, word}; used for reads and for byte-lane merge
	function automatic logic [32:0] reg_read(input logic [11:0] a);
		logic [11:0] i;
		logic [32:0] r;
		r = 33'h0_0000_0000;
		i = {2'h0, a[11:2]};
		if (in_rgn(a, `QBC_PORT_BASE, `QBC_NPORT))
			r = {1'b1, 13'h0000, port_cfg[2'(i)]};
		else if (in_rgn(a, `QBC_LEG_BASE, `QBC_NLEG))
			r = {1'b1, 24'h00_0000, leg_cfg[2'(i)]};
		else if (in_rgn(a, `QBC_REWR_BASE, `QBC_NCLASS))
			r = {1'b1, 26'h000_0000, rewr_mem[3'(i)]};
		else if (in_rgn(a, `QBC_CPC_BASE, `QBC_NCP))
			r = {1'b1, 29'h0000_0000, cpc_mem[5'(i)]};
		else if (in_rgn(a, `QBC_CODE_BASE, `QBC_NCODE))
			r = {1'b1, 20'h0_0000, code_mem[6'(i)]};
		else if (in_rgn(a, `QBC_TMAP_BASE, `QBC_NTMAP))
			r = {1'b1, 27'h000_0000, tmap_mem[6'(i)]};
		else if (a == `QBC_STAT_ADDR)
			r = {1'b1, cnt_reg, 2'h0, result_out.svc_class,
				result_out.code, result_out.drop_prec,
				result_out.prio_class};
		return r;
	endfunction

	qbc_axil_slave u_bus (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.s_awaddr  (s_awaddr),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_bresp   (s_bresp),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_araddr  (s_araddr),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.wr_go     (wr_go),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data),
		.wr_strb   (wr_strb),
		.wr_hit    (wr_old[32]),
		.rd_addr   (rd_addr),
		.rd_data   (rd_word[31:0]),
		.rd_hit    (rd_word[32])
	);

	always_comb begin
		rd_word = reg_read(rd_addr);
		wr_old  = reg_read(wr_addr);
		for (int b = 0; b < 4; b++) begin
			wr_new[b*8 +: 8] = wr_strb[b] ? wr_data[b*8 +: 8]
				: wr_old[b*8 +: 8];
		end
	end

	// configuration storage, status word is read only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int k = 0; k < `QBC_NPORT; k++)
				port_cfg[k] <= `QBC_PORT_RST;
			for (int k = 0; k < `QBC_NLEG; k++)
				leg_cfg[k] <= 8'h00;
			for (int k = 0; k < `QBC_NCLASS; k++)
				rewr_mem[k] <= 6'h00;
			for (int k = 0; k < `QBC_NCP; k++)
				cpc_mem[k] <= 3'h0;
			for (int k = 0; k < `QBC_NCODE; k++)
				code_mem[k] <= 12'h000;
			for (int k = 0; k < `QBC_NTMAP; k++)
				tmap_mem[k] <= 5'h00;
		end else if (wr_go) begin
			if (in_rgn(wr_addr, `QBC_PORT_BASE, `QBC_NPORT))
				port_cfg[wr_addr[3:2]] <= wr_new[18:0];
			if (in_rgn(wr_addr, `QBC_LEG_BASE, `QBC_NLEG))
				leg_cfg[wr_addr[3:2]] <= wr_new[7:0];
			if (in_rgn(wr_addr, `QBC_REWR_BASE, `QBC_NCLASS))
				rewr_mem[wr_addr[4:2]] <= wr_new[5:0];
			if (in_rgn(wr_addr, `QBC_CPC_BASE, `QBC_NCP))
				cpc_mem[wr_addr[6:2]] <= wr_new[2:0];
			if (in_rgn(wr_addr, `QBC_CODE_BASE, `QBC_NCODE))
				code_mem[wr_addr[7:2]] <= wr_new[11:0];
			if (in_rgn(wr_addr, `QBC_TMAP_BASE, `QBC_NTMAP))
				tmap_mem[wr_addr[7:2]] <= wr_new[4:0];
		end
	end

	// classification datapath
	logic [18:0] pcfg;
	logic [7:0]  ipcfg;
	logic        use_leg;
	logic        has_tag;
	logic [2:0]  tag_pcp;
	logic        tag_dei;
	logic [4:0]  tmap_q;
	logic [5:0]  raw_code;
	logic [5:0]  tr_code;
	logic [11:0] tr_entry;
	logic        trusted;
	logic [2:0]  cp_q;
	logic [2:0]  base_qos;
	logic [1:0]  base_drop;
	logic [2:0]  fin_qos;
	logic [5:0]  fin_code;

	qbc_tag_select u_tag (
		.tags      (frame_in.tags),
		.tag_cnt   (frame_in.tag_cnt),
		.tpid_ok   (pcfg[`QBC_F_TPID]),
		.inner_sel (pcfg[`QBC_F_INNER]),
		.has_tag   (has_tag),
		.pcp       (tag_pcp),
		.dei       (tag_dei)
	);

	always_comb begin
		pcfg = port_cfg[frame_in.port];
		use_leg = frame_in.from_second_vdev && frame_in.rleg_valid;
		// leg word shares layout of the IP part of the port word
		ipcfg = use_leg ? leg_cfg[frame_in.rleg] : pcfg[7:0];
		tmap_q = tmap_mem[{frame_in.port, tag_dei, tag_pcp}];
		raw_code = frame_in.is_ip ? frame_in.code : 6'h00;
		// one translation feeds class, precedence and codepoint
		tr_code = ipcfg[`QBC_F_TRE] ?
			code_mem[raw_code][`QBC_F_TRVAL] : raw_code;
		if (!frame_in.is_ip)
			tr_code = 6'h00;
		tr_entry = code_mem[tr_code];
		// one trust decision shared by class and precedence
		trusted = frame_in.is_ip && ipcfg[`QBC_F_CODEE] &&
			tr_entry[`QBC_F_TRUST];
		cp_q = cpc_mem[frame_in.l2cp_idx];
		if (pcfg[`QBC_F_TAGE] && has_tag) begin
			base_qos  = tmap_q[`QBC_F_QOS];
			base_drop = tmap_q[`QBC_F_DROP];
		end else begin
			base_qos  = ipcfg[`QBC_F_QOS];
			base_drop = ipcfg[`QBC_F_DROP];
		end
		if (trusted) begin
			base_qos  = tr_entry[`QBC_F_QOS];
			base_drop = tr_entry[`QBC_F_DROP];
		end
		fin_qos = frame_in.l2cp_cpu ? cp_q : base_qos;
		fin_code = (frame_in.is_ip && pcfg[`QBC_F_REWE]) ?
			rewr_mem[base_qos] : tr_code;
	end

	// results feed later stages that may still replace them
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			result_valid <= 1'b0;
			result_out   <= '0;
		end else begin
			result_valid <= frame_valid;
			if (frame_valid) begin
				result_out.prio_class  <= fin_qos;
				result_out.drop_prec   <= base_drop;
				result_out.code        <= fin_code;
				result_out.svc_class   <= pcfg[`QBC_F_SVC];
				result_out.transp_code <= pcfg[`QBC_F_KEEP];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			cnt_reg <= 16'h0000;
		else if (frame_valid)
			cnt_reg <= cnt_reg + 16'h0001;
	end

	sequence frame_taken_s;
		frame_valid && !frame_in.l2cp_cpu;
	endsequence

	out_pulse_a: assert property (
		frame_valid |=> result_valid ##1
			(result_valid == $past(frame_valid)))
		else $error("result valid does not follow frame valid");
	cp_class_a: assert property (
		frame_valid && frame_in.l2cp_cpu |=>
			result_out.prio_class == $past(cp_q))
		else $error("control protocol class not applied");
	nonip_code_a: assert property (
		frame_valid && !frame_in.is_ip |=> result_out.code == 6'h00)
		else $error("non IP frame codepoint not zero");
	keep_flag_a: assert property (
		frame_valid |=>
			result_out.transp_code == $past(pcfg[`QBC_F_KEEP]))
		else $error("transparent flag differs from keep bit");
	svc_default_a: assert property (
		frame_valid |=>
			result_out.svc_class == $past(pcfg[`QBC_F_SVC]))
		else $error("service class not port default");
	trust_wins_a: assert property (
		frame_taken_s ##0 trusted |=>
			result_out.prio_class == $past(tr_entry[`QBC_F_QOS]) &&
			result_out.drop_prec == $past(tr_entry[`QBC_F_DROP]))
		else $error("trusted codepoint class not applied");
	leg_default_a: assert property (
		frame_taken_s ##0 (use_leg && !trusted &&
			!(pcfg[`QBC_F_TAGE] && has_tag)) |=>
			result_out.prio_class ==
				$past(leg_cfg[frame_in.rleg][`QBC_F_QOS]))
		else $error("router leg default class not applied");
	tag_map_a: assert property (
		frame_taken_s ##0 (!trusted && pcfg[`QBC_F_TAGE] && has_tag) |=>
			result_out.drop_prec == $past(tmap_q[`QBC_F_DROP]))
		else $error("tag map precedence not applied");
	tag_class_a: assert property (
		frame_taken_s ##0 (!trusted && pcfg[`QBC_F_TAGE] && has_tag) |=>
			result_out.prio_class == $past(tmap_q[`QBC_F_QOS]))
		else $error("tag map class not applied");
	port_default_a: assert property (
		frame_taken_s ##0 (!use_leg && !trusted &&
			!(pcfg[`QBC_F_TAGE] && has_tag)) |=>
			result_out.prio_class == $past(pcfg[`QBC_F_QOS]) &&
			result_out.drop_prec == $past(pcfg[`QBC_F_DROP]))
		else $error("port default class not applied");
	rewrite_code_a: assert property (
		frame_valid && frame_in.is_ip && pcfg[`QBC_F_REWE] |=>
			result_out.code == $past(rewr_mem[base_qos]))
		else $error("class rewrite codepoint not applied");
endmodule // qbc_classifier
`default_nettype wire

/* verif/qbc_frame_src.sv */
`timescale 1ns/1ps
`default_nettype none
module qbc_frame_src (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic                req,
	input  wire qbc_pkg::qbc_frame_t req_frame,
	output logic                     frame_valid,
	output qbc_pkg::qbc_frame_t      frame_in
);
	// one-cycle frame strobe; idle fields toggle every cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			frame_valid <= 1'b0;
			frame_in    <= '0;
		end else if (req) begin
			frame_valid <= 1'b1;
			frame_in    <= req_frame;
		end else begin
			frame_valid <= 1'b0;
			frame_in    <= ~frame_in;
		end
	end
endmodule // qbc_frame_src
`default_nettype wire

/* verif/test_qos_basic_classifier.sv */
`timescale 1ns/1ps
`default_nettype none
`include "qbc_map.svh"
module test_qos_basic_classifier;
	logic                 clk_sys, rst, req;
	logic [11:0]          s_awaddr, s_araddr;
	logic [31:0]          s_wdata, s_rdata;
	logic [3:0]           s_wstrb;
	logic [1:0]           s_bresp, s_rresp;
	logic                 s_awvalid, s_awready, s_wvalid, s_wready;
	logic                 s_bvalid, s_bready, s_arvalid, s_arready;
	logic                 s_rvalid, s_rready, frame_valid, result_valid;
	qbc_pkg::qbc_frame_t  frame_in, req_frame, f;
	qbc_pkg::qbc_result_t result_out;
	int                   mismatches, checked, cycles;

	qbc_classifier u_qbc_classifier (
		.clk_sys(clk_sys), .rst(rst),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready),
		.frame_valid(frame_valid), .frame_in(frame_in),
		.result_valid(result_valid), .result_out(result_out)
	);

	qbc_frame_src u_qbc_frame_src (
		.clk_sys(clk_sys), .rst(rst), .req(req), .req_frame(req_frame),
		.frame_valid(frame_valid), .frame_in(frame_in)
	);

	always #5 clk_sys = ~clk_sys;

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk_sys);
		s_awaddr <= a;
		s_awvalid <= 1'b1;
		s_wdata <= d;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
			if (s_bvalid) break;
		end
		s_bready <= 1'b0;
		chk({30'h0, s_bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge clk_sys);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_arready) s_arvalid <= 1'b0;
			if (s_rvalid) break;
		end
		s_rready <= 1'b0;
		chk({30'h0, s_rresp}, {30'h0, er});
		chk(s_rdata, ed);
	endtask

	function automatic qbc_pkg::qbc_result_t r(input logic [2:0] q,
		input logic [1:0] d, input logic [5:0] c, input logic [2:0] s,
		input logic t);
		r = {q, d, c, s, t};
	endfunction

	// frame offered by the parser model, result one edge after it is taken
	task automatic frm(input qbc_pkg::qbc_result_t ex);
		@(posedge clk_sys);
		req <= 1'b1;
		req_frame <= f;
		@(posedge clk_sys);
		req <= 1'b0;
		@(posedge clk_sys);
		@(posedge clk_sys);
		chk({16'h0, result_valid, result_out}, {16'h0, 1'b1, ex});
		@(posedge clk_sys);
		chk({31'h0, result_valid}, 32'h0);
	endtask

	task automatic done(input string n);
		$display("test %s done", n);
	endtask

	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		req = 1'b0;
		req_frame = '0;
		s_awaddr = 12'h000;
		s_awvalid = 1'b0;
		s_wdata = 32'h0;
		s_wstrb = 4'hF;
		s_wvalid = 1'b0;
		s_bready = 1'b0;
		s_araddr = 12'h000;
		s_arvalid = 1'b0;
		s_rready = 1'b0;
		f = '0;
		mismatches = 0;
		checked = 0;
		cycles = 0;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		rd(12'h004, 32'h0007C000, `QBC_RESP_OK);
		rd(12'h47C, 32'h0, `QBC_RESP_OK);
		rd(12'h7FC, 32'h0, `QBC_RESP_ERR);
		wr(12'h7FC, 32'hFFFFFFFF, `QBC_RESP_ERR);
		wr(12'h2A8, 32'hFFFFF46C, `QBC_RESP_OK);
		rd(12'h2A8, 32'h0000046C, `QBC_RESP_OK);
		done("registers");
		frm(r(3'h0, 2'h0, 6'h00, 3'h0, 1'b0));
		wr(12'h004, 32'h0007DA15, `QBC_RESP_OK);
		f.port = 2'h1;
		f.code = 6'h2A;
		frm(r(3'h5, 2'h2, 6'h00, 3'h6, 1'b1));
		done("defaults");
		f.tag_cnt = 2'h2;
		f.tags[0] = {3'h0, 3'h3, 1'b0};
		f.tags[1] = {3'h1, 3'h6, 1'b1};
		f.tags[2] = {3'h2, 3'h5, 1'b1};
		wr(12'h44C, 32'h0000000A, `QBC_RESP_OK);
		wr(12'h478, 32'h0000001F, `QBC_RESP_OK);
		frm(r(3'h5, 2'h2, 6'h00, 3'h6, 1'b1));
		wr(12'h004, 32'h0007DA35, `QBC_RESP_OK);
		frm(r(3'h2, 2'h1, 6'h00, 3'h6, 1'b1));
		wr(12'h004, 32'h0007DB35, `QBC_RESP_OK);
		frm(r(3'h7, 2'h3, 6'h00, 3'h6, 1'b1));
		f.tag_cnt = 2'h3;
		frm(r(3'h7, 2'h3, 6'h00, 3'h6, 1'b1));
		wr(12'h004, 32'h00075B35, `QBC_RESP_OK);
		frm(r(3'h2, 2'h1, 6'h00, 3'h6, 1'b1));
		done("tags");
		f.tag_cnt = 2'h0;
		f.is_ip = 1'b1;
		wr(12'h004, 32'h0007DA15, `QBC_RESP_OK);
		frm(r(3'h5, 2'h2, 6'h2A, 3'h6, 1'b1));
		wr(12'h004, 32'h0007DA55, `QBC_RESP_OK);
		frm(r(3'h4, 2'h1, 6'h2A, 3'h6, 1'b1));
		wr(12'h004, 32'h0007DAD5, `QBC_RESP_OK);
		frm(r(3'h5, 2'h2, 6'h11, 3'h6, 1'b1));
		wr(12'h244, 32'h0000003E, `QBC_RESP_OK);
		frm(r(3'h6, 2'h3, 6'h11, 3'h6, 1'b1));
		wr(12'h004, 32'h0007FA55, `QBC_RESP_OK);
		wr(12'h090, 32'h00000033, `QBC_RESP_OK);
		frm(r(3'h4, 2'h1, 6'h33, 3'h6, 1'b1));
		wr(12'h17C, 32'h00000006, `QBC_RESP_OK);
		f.l2cp_cpu = 1'b1;
		f.l2cp_idx = 5'h1F;
		frm(r(3'h6, 2'h1, 6'h33, 3'h6, 1'b1));
		f.l2cp_cpu = 1'b0;
		done("codepoint");
		wr(12'h004, 32'h0007DA55, `QBC_RESP_OK);
		wr(12'h048, 32'h0000000B, `QBC_RESP_OK);
		f.from_second_vdev = 1'b1;
		f.rleg = 2'h2;
		frm(r(3'h4, 2'h1, 6'h2A, 3'h6, 1'b1));
		f.rleg_valid = 1'b1;
		frm(r(3'h3, 2'h1, 6'h2A, 3'h6, 1'b1));
		wr(12'h048, 32'h000000CB, `QBC_RESP_OK);
		frm(r(3'h6, 2'h3, 6'h11, 3'h6, 1'b1));
		rd(12'h600, 32'h0010323E, `QBC_RESP_OK);
		done("router leg");
		tally_and_finish();
	end
endmodule // test_qos_basic_classifier
`default_nettype wire
